/* File: hw/ata_cmd_exec.sv */
// Command interpreter for verify, recalibrate, security disable password and security erase commands
// What this block does
// R1: Opcodes 40h and 41h are verify; low bit is retry control.
// R2: Verify reads and checks sectors, sends no data to host.
// R3: Verify count zero means 256 sectors.
// R4: Uncorrectable error stops verify at the failing sector.
// R5: Count register ends holding sectors not verified.
// R6: LBA bits split over sector, cylinder low, high and head.
// R7: Retry bit set disables internal retries.
// R8: Address registers report last processed sector.
// R9: Any 1xh opcode recalibrates heads to cylinder zero.
// R10: Failing to reach cylinder zero sets track-zero error, reports error.
// R11: F6h takes password sector; match disables lock function.
// R12: Host sends selector word, 32-byte password, reserved words.
// R13: Selector zero compares user password, one compares master.
// R14: Lock disable leaves master password stored.
// R15: Host should disable lock only while device unlocked.
// R16: Host issues F3h right before secure erase.
// R17: Erase prepare completes without data transfer.
// R18: F4h erases LBA 0 to native max, ignoring host max.
// R19: Password mismatch on erase aborts command.
// R20: Erase without immediately preceding prepare aborts.
// R21: Erase writes zeros, no readback, no defect update, disables lock.
// R22: Lock already disabled skips password compare on erase.
// R23: Password commands raise data request for exactly 256 words.
`timescale 1ns/1ps
module ata_cmd_exec (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire ata_cmd_pkg::task_file_t tf_wr,
   input wire logic tf_load,
   input wire logic [7:0] opcode_entry,
   input wire logic opcode_wr,
   input wire logic data_wr,
   input wire logic [15:0] data_in,
   input wire logic [255:0] user_pw,
   input wire logic [255:0] master_pw,
   input wire logic lock_enabled,
   input wire logic [27:0] native_max,
   input wire logic media_done,
   input wire logic media_unc,
   input wire logic media_idnf,
   input wire logic track0_found,
   output ata_cmd_pkg::task_file_t tf_rd,
   output logic [7:0] error_flags,
   output logic [7:0] drive_state_flags,
   output ata_cmd_pkg::media_req_t media_req,
   output logic media_go,
   output logic lock_disable
);
   import ata_cmd_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_VERIFY = 3'b001,
      S_RECAL = 3'b010,
      S_PW_IN = 3'b011,
      S_ERASE = 3'b100
   } state_t;

   state_t state_q;
   logic is_erase_q;
   logic prep_armed_q;
   logic [8:0] left_q;
   logic [27:0] lba_q;
   logic pw_start;
   logic pw_done;
   logic pw_match;

   // Gather the 28-bit block address from the task file
   function automatic logic [27:0] tf_lba(input task_file_t t);
      tf_lba = {t.dev_head[3:0], t.cyl_hi, t.cyl_lo, t.sector};
   endfunction

   // Next consecutive CHS-or-LBA location; CHS wrap is kept linear here
   function automatic logic [27:0] lba_next(input logic [27:0] a);
      lba_next = a + 28'h0000001;
   endfunction

   password_check u_pw (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .start(pw_start),
      .word_wr(data_wr && state_q == S_PW_IN),
      .word_data(data_in),
      .user_pw(user_pw),
      .master_pw(master_pw),
      .done(pw_done),
      .match(pw_match),
      .master_sel()
   );

   // Password intake starts as soon as a password command is taken
   assign pw_start = opcode_wr && state_q == S_IDLE &&
      (opcode_entry == OP_LOCK_OFF ||
       (opcode_entry == OP_ERASE_UNIT && prep_armed_q && lock_enabled));

   // Command sequencer
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= S_IDLE;
         is_erase_q <= 1'b0;
      end else begin
         unique case (state_q)
            S_IDLE: begin
               if (opcode_wr) begin
                  // R1: verify decode
                  if (opcode_entry[7:1] == OP_VERIFY[7:1])
                     state_q <= S_VERIFY;
                  // R9: recalibrate decode
                  else if (opcode_entry[7:4] == OP_RECAL_HI)
                     state_q <= S_RECAL;
                  // R11: lock disable takes sector
                  else if (opcode_entry == OP_LOCK_OFF) begin
                     state_q <= S_PW_IN;
                     is_erase_q <= 1'b0;
                  end else if (opcode_entry == OP_ERASE_UNIT &&
                               prep_armed_q) begin
                     // R22: unlocked skips compare
                     if (lock_enabled) begin
                        state_q <= S_PW_IN;
                        is_erase_q <= 1'b1;
                     end else
                        state_q <= S_ERASE;
                  end
               end
            end
            S_VERIFY: begin
               // R4: stop on failure
               if (media_done && (media_unc || media_idnf ||
                   left_q == 9'h001))
                  state_q <= S_IDLE;
            end
            S_RECAL: begin
               if (media_done)
                  state_q <= S_IDLE;
            end
            S_PW_IN: begin
               // R19: mismatch aborts erase
               if (pw_done)
                  state_q <= (is_erase_q && pw_match) ? S_ERASE : S_IDLE;
            end
            S_ERASE: begin
               // R18: stop after native max
               if (media_done && lba_q == native_max)
                  state_q <= S_IDLE;
            end
         endcase
      end
   end

   // R20: prepare arms only next command
   // Any command other than prepare disarms it, erase included
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         prep_armed_q <= 1'b0;
      else if (opcode_wr && state_q == S_IDLE)
         prep_armed_q <= (opcode_entry == OP_ERASE_PREP);
   end

   // Sector count and address walk during verify, address walk during erase
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         left_q <= 9'h000;
         lba_q <= LBA_ZERO;
      end else if (opcode_wr && state_q == S_IDLE) begin
         // R3: zero means 256
         left_q <= (tf_rd.count == 8'h00) ? FULL_COUNT :
                   {1'b0, tf_rd.count};
         // Erase walks from block zero, whatever the task file holds
         lba_q <= (opcode_entry == OP_ERASE_UNIT) ? LBA_ZERO :
                  tf_lba(tf_rd);
      end else if (state_q == S_VERIFY && media_done &&
                   !media_unc && !media_idnf) begin
         left_q <= left_q - 9'h001;
         if (left_q != 9'h001)
            lba_q <= lba_next(lba_q);
      end else if (state_q == S_ERASE && media_done &&
                   lba_q != native_max) begin
         lba_q <= lba_next(lba_q);
      end
   end

   // Media requests; verify never touches the data register
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         media_req <= '0;
         media_go <= 1'b0;
      end else begin
         media_go <= 1'b0;
         if (opcode_wr && state_q == S_IDLE) begin
            // R7: retry bit passed
            media_req.no_retry <= opcode_entry[0];
         end
         if (state_q == S_IDLE && opcode_wr &&
             opcode_entry[7:1] == OP_VERIFY[7:1]) begin
            // R2: verify without transfer
            media_req.verify <= 1'b1;
            media_req.recal <= 1'b0;
            media_req.erase <= 1'b0;
            media_req.lba <= tf_lba(tf_rd);
            media_go <= 1'b1;
         end else if (state_q == S_VERIFY && media_done &&
                      !media_unc && !media_idnf && left_q != 9'h001) begin
            media_req.lba <= lba_next(lba_q);
            media_go <= 1'b1;
         end else if (state_q == S_IDLE && opcode_wr &&
                      opcode_entry[7:4] == OP_RECAL_HI) begin
            media_req.verify <= 1'b0;
            media_req.recal <= 1'b1;
            media_req.erase <= 1'b0;
            media_go <= 1'b1;
         end else if ((state_q == S_PW_IN && pw_done && is_erase_q &&
                       pw_match) ||
                      (state_q == S_IDLE && opcode_wr && !lock_enabled &&
                       opcode_entry == OP_ERASE_UNIT && prep_armed_q)) begin
            // R18: erase through native max
            // R21: zero fill, no readback
            media_req.verify <= 1'b0;
            media_req.recal <= 1'b0;
            media_req.erase <= 1'b1;
            media_req.lba <= LBA_ZERO;
            media_go <= 1'b1;
         end else if (state_q == S_ERASE && media_done &&
                      lba_q != native_max) begin
            // One media step per block, hidden area included
            media_req.lba <= lba_next(lba_q);
            media_go <= 1'b1;
         end
      end
   end

   // R14: master kept, only lock cleared
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         lock_disable <= 1'b0;
      else
         // Erase clears the lock only once the last block is written
         lock_disable <= (state_q == S_PW_IN && pw_done && pw_match &&
                          !is_erase_q) ||
                         (state_q == S_ERASE && media_done &&
                          lba_q == native_max);
   end

   // Task file: host loads, device reports back after verify
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tf_rd <= '0;
         tf_rd.count <= 8'h01;
         tf_rd.sector <= 8'h01;
         tf_rd.dev_head <= DH_FIXED;
      end else if (tf_load && state_q == S_IDLE) begin
         tf_rd <= tf_wr;
      end else if (state_q == S_VERIFY && media_done) begin
         // R5: count left unverified
         tf_rd.count <= (media_unc || media_idnf) ? left_q[7:0] :
                        left_q[7:0] - 8'h01;
         // R8: last processed address
         // R6: LBA field split
         if (tf_rd.dev_head[DH_LBA]) begin
            tf_rd.sector <= lba_q[7:0];
            tf_rd.cyl_lo <= lba_q[15:8];
            tf_rd.cyl_hi <= lba_q[23:16];
            tf_rd.dev_head[3:0] <= lba_q[27:24];
         end else begin
            tf_rd.sector <= lba_q[7:0];
         end
      end
   end

   // Status and error registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         drive_state_flags <= STATUS_IDLE;
         error_flags <= 8'h00;
      end else if (state_q == S_IDLE && opcode_wr) begin
         error_flags <= 8'h00;
         drive_state_flags <= 8'h00;
         if (pw_start) begin
            // R23: request password sector
            drive_state_flags[ST_DRQ] <= 1'b1;
            drive_state_flags[ST_RDY] <= 1'b1;
         end else if (opcode_entry == OP_ERASE_PREP ||
                      (opcode_entry == OP_ERASE_UNIT && !prep_armed_q) ||
                      !(opcode_entry[7:1] == OP_VERIFY[7:1] ||
                        opcode_entry[7:4] == OP_RECAL_HI ||
                        opcode_entry == OP_ERASE_UNIT)) begin
            // R17: prepare ends at once
            drive_state_flags <= STATUS_IDLE;
            if (opcode_entry != OP_ERASE_PREP) begin
               error_flags[ERR_ABT] <= 1'b1;
               drive_state_flags[ST_ERR] <= 1'b1;
            end
         end else
            drive_state_flags[ST_BSY] <= 1'b1;
      end else if (state_q == S_PW_IN && pw_done) begin
         drive_state_flags <= is_erase_q && pw_match ? 8'h80 : STATUS_IDLE;
         if (!pw_match) begin
            error_flags[ERR_ABT] <= 1'b1;
            drive_state_flags[ST_ERR] <= 1'b1;
         end
      end else if (media_done && (state_q == S_RECAL ||
                   (state_q == S_ERASE && lba_q == native_max) ||
                   (state_q == S_VERIFY && (media_unc || media_idnf ||
                    left_q == 9'h001)))) begin
         drive_state_flags <= STATUS_IDLE;
         if (state_q == S_VERIFY && (media_unc || media_idnf)) begin
            error_flags[ERR_UNC] <= media_unc;
            error_flags[ERR_IDN] <= media_idnf;
            drive_state_flags[ST_ERR] <= 1'b1;
         end
         // R10: track zero missing
         if (state_q == S_RECAL && !track0_found) begin
            error_flags[ERR_TON] <= 1'b1;
            error_flags[ERR_ABT] <= 1'b1;
            drive_state_flags[ST_ERR] <= 1'b1;
         end
      end
   end
endmodule

/* File: hw/ata_cmd_pkg.sv */
// Constants and types shared by the command interpreter files
package ata_cmd_pkg;
   // Opcodes
   localparam logic [7:0] OP_VERIFY = 8'h40;
   localparam logic [3:0] OP_RECAL_HI = 4'h1;
   localparam logic [7:0] OP_LOCK_OFF = 8'hf6;
   localparam logic [7:0] OP_ERASE_PREP = 8'hf3;
   localparam logic [7:0] OP_ERASE_UNIT = 8'hf4;
   // Error register bit positions
   localparam int ERR_UNC = 6;
   localparam int ERR_IDN = 4;
   localparam int ERR_ABT = 2;
   localparam int ERR_TON = 1;
   // Status register bit positions
   localparam int ST_BSY = 7;
   localparam int ST_RDY = 6;
   localparam int ST_DSC = 4;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;
   // Device/head field positions
   localparam int DH_LBA = 6;
   localparam logic [7:0] DH_FIXED = 8'ha0;
   localparam logic [7:0] STATUS_IDLE = 8'h50;
   // Password sector layout, in 16-bit words
   localparam int SECTOR_WORDS = 256;
   localparam int PW_FIRST = 1;
   localparam int PW_LAST = 16;
   localparam logic [8:0] FULL_COUNT = 9'h100;
   localparam logic [7:0] WORD_LAST = 8'hff;
   localparam logic [27:0] LBA_ZERO = 28'h0000000;

   // Command block registers as seen by the host
   typedef struct packed {
      logic [7:0] count;
      logic [7:0] sector;
      logic [7:0] cyl_lo;
      logic [7:0] cyl_hi;
      logic [7:0] dev_head;
   } task_file_t;

   // Media engine request
   typedef struct packed {
      logic verify;
      logic recal;
      logic erase;
      logic no_retry;
      logic [27:0] lba;
   } media_req_t;
endpackage

/* File: hw/password_check.sv */
// Password sector intake and comparison against stored passwords
`timescale 1ns/1ps
module password_check (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic start,
   input wire logic word_wr,
   input wire logic [15:0] word_data,
   input wire logic [255:0] user_pw,
   input wire logic [255:0] master_pw,
   output logic done,
   output logic match,
   output logic master_sel
);
   import ata_cmd_pkg::*;

   logic [7:0] idx_q;
   logic busy_q;
   logic diff_q;

   // Word counter runs over one whole sector
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         idx_q <= 8'h00;
         busy_q <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            idx_q <= 8'h00;
            busy_q <= 1'b1;
         end else if (busy_q && word_wr) begin
            idx_q <= idx_q + 8'h01;
            if (idx_q == WORD_LAST) begin
               busy_q <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end

   // R13: select stored password
   // Word 0 bit 0 picks master; words 1-16 compared, rest ignored
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         master_sel <= 1'b0;
         diff_q <= 1'b0;
      end else if (start) begin
         diff_q <= 1'b0;
      end else if (busy_q && word_wr) begin
         if (idx_q == 8'h00) begin
            master_sel <= word_data[0];
         end else if (idx_q >= 8'(PW_FIRST) && idx_q <= 8'(PW_LAST)) begin
            if (word_data != (master_sel ?
                  master_pw[16*(idx_q-8'(PW_FIRST)) +: 16] :
                  user_pw[16*(idx_q-8'(PW_FIRST)) +: 16]))
               diff_q <= 1'b1;
         end
      end
   end

   assign match = !diff_q;
endmodule

/* File: testbench/ata_cmd_checker.sv */
// Port assertions for the command interpreter
`timescale 1ns/1ps
module ata_cmd_checker (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [7:0] opcode_entry,
   input wire logic opcode_wr,
   input wire logic data_wr,
   input wire logic lock_enabled,
   input wire logic [27:0] native_max,
   input wire logic media_done,
   input wire logic media_unc,
   input wire logic track0_found,
   input wire logic [7:0] error_flags,
   input wire logic [7:0] drive_state_flags,
   input wire ata_cmd_pkg::media_req_t media_req,
   input wire logic media_go
);
   import ata_cmd_pkg::*;
   logic take;
   logic busy;
   logic drq;
   logic armed_q;
   logic [8:0] words_q;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // Opcode accepted only while neither busy nor requesting data
   assign busy = drive_state_flags[ST_BSY];
   assign drq = drive_state_flags[ST_DRQ];
   assign take = opcode_wr && !busy && !drq;
   // Any accepted opcode other than erase prepare disarms the erase
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         armed_q <= 1'b0;
      end else if (take) begin
         armed_q <= (opcode_entry == OP_ERASE_PREP);
      end
   end
   // Words accepted while data is requested
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         words_q <= 9'h000;
      end else if (take) begin
         words_q <= 9'h000;
      end else if (data_wr && drq) begin
         words_q <= words_q + 9'h001;
      end
   end
   property p_verify_go;
      take && opcode_entry[7:1] == OP_VERIFY[7:1] |=> media_go &&
         media_req.verify && media_req.no_retry == $past(opcode_entry[0]);
   endproperty
   a_verify_go: assert property (p_verify_go)
      else $error("verify start wrong");
   property p_no_data;
      busy && media_req.verify |-> !drq;
   endproperty
   a_no_data: assert property (p_no_data)
      else $error("data request during verify");
   property p_unc_stop;
      media_done && busy && media_req.verify && media_unc |=>
         !media_go && !busy && error_flags[ERR_UNC];
   endproperty
   a_unc_stop: assert property (p_unc_stop)
      else $error("verify went on after error");
   property p_recal_go;
      take && opcode_entry[7:4] == OP_RECAL_HI |=> media_go && media_req.recal;
   endproperty
   a_recal_go: assert property (p_recal_go)
      else $error("recal start wrong");
   property p_track0;
      media_done && busy && media_req.recal && !track0_found |=>
         error_flags[ERR_TON] && drive_state_flags[ST_ERR];
   endproperty
   a_track0: assert property (p_track0)
      else $error("track zero error missing");
   property p_prep;
      take && opcode_entry == OP_ERASE_PREP |=> (!drq) [*3];
   endproperty
   a_prep: assert property (p_prep)
      else $error("prepare asked for data");
   property p_unarmed;
      take && opcode_entry == OP_ERASE_UNIT && !armed_q |=>
         error_flags[ERR_ABT] && drive_state_flags[ST_ERR];
   endproperty
   a_unarmed: assert property (p_unarmed)
      else $error("unarmed erase not aborted");
   property p_open_erase;
      take && opcode_entry == OP_ERASE_UNIT && armed_q && !lock_enabled |=>
         media_go && media_req.erase && media_req.lba == LBA_ZERO;
   endproperty
   a_open_erase: assert property (p_open_erase)
      else $error("open erase start wrong");
   property p_erase_range;
      media_go && media_req.erase |-> media_req.lba <= native_max;
   endproperty
   a_erase_range: assert property (p_erase_range)
      else $error("erase beyond native max");
   property p_sector;
      $fell(drq) |-> words_q == FULL_COUNT;
   endproperty
   a_sector: assert property (p_sector)
      else $error("sector length wrong");
   c_erase: cover property (take && opcode_entry == OP_ERASE_UNIT && armed_q);
   c_unc: cover property (media_done && media_unc && busy);
   c_sector: cover property ($fell(drq));
endmodule

/* File: testbench/host_model.sv */
// Host controller model driving the task file and data port
`timescale 1ns/1ps
module host_model (
   input wire logic core_clk,
   output ata_cmd_pkg::task_file_t tf_wr,
   output logic tf_load,
   output logic [7:0] opcode_entry,
   output logic opcode_wr,
   output logic data_wr,
   output logic [15:0] data_in
);
   import ata_cmd_pkg::*;
   initial begin
      tf_wr = '0;
      tf_load = 1'b0;
      opcode_entry = 8'h00;
      opcode_wr = 1'b0;
      data_wr = 1'b0;
      data_in = 16'h0000;
   end
   // Load the task file, then strobe the opcode one cycle later
   task automatic issue(input task_file_t tf, input logic [7:0] op);
      @(negedge core_clk);
      tf_wr = tf;
      tf_load = 1'b1;
      @(negedge core_clk);
      tf_load = 1'b0;
      opcode_entry = op;
      opcode_wr = 1'b1;
      @(negedge core_clk);
      opcode_wr = 1'b0;
      opcode_entry = ~op;
      @(negedge core_clk);
   endtask
   // whole sector, gap sets a slow host
   task automatic send_sector(input logic sel, input logic [255:0] pw,
                              input int gap);
      int i;
      for (i = 0; i < SECTOR_WORDS; i++) begin
         @(negedge core_clk);
         data_wr = 1'b1;
         data_in = 16'h0000;
         if (i == 0) data_in = {15'h0000, sel};
         if (i >= PW_FIRST && i <= PW_LAST) data_in = pw[16*(i-1)+:16];
         @(negedge core_clk);
         data_wr = 1'b0;
         // Released bus shows a changing pattern, not the last word
         data_in = ~data_in;
         repeat (gap) @(negedge core_clk);
      end
   endtask
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the command interpreter
`timescale 1ns/1ps
module tb_top;
   import ata_cmd_pkg::*;
   localparam logic [255:0] PW_U = {16{16'h5a3c}};
   localparam logic [255:0] PW_M = {16{16'hc3a5}};
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic lock_enabled = 1'b1;
   logic media_done = 1'b0;
   logic media_unc = 1'b0;
   logic track0_found = 1'b1;
   logic t0_ok = 1'b1;
   logic [27:0] native_max = 28'h0000003;
   logic tf_load, opcode_wr, data_wr, media_go, lock_disable;
   logic [7:0] opcode_entry, error_flags, drive_state_flags;
   logic [15:0] data_in;
   task_file_t tf_wr, tf_rd;
   media_req_t media_req, first_req, last_req;
   int n_go, n_unlock, unc_at, n_errors, checks_done;
   always #5 core_clk = ~core_clk;
   host_model host (.core_clk(core_clk), .tf_wr(tf_wr), .tf_load(tf_load),
      .opcode_entry(opcode_entry), .opcode_wr(opcode_wr),
      .data_wr(data_wr), .data_in(data_in));
   ata_cmd_exec dut (.core_clk(core_clk), .rst_b(rst_b), .tf_wr(tf_wr),
      .tf_load(tf_load), .opcode_entry(opcode_entry), .opcode_wr(opcode_wr),
      .data_wr(data_wr), .data_in(data_in), .user_pw(PW_U),
      .master_pw(PW_M), .lock_enabled(lock_enabled),
      .native_max(native_max), .media_done(media_done),
      .media_unc(media_unc), .media_idnf(1'b0),
      .track0_found(track0_found), .tf_rd(tf_rd),
      .error_flags(error_flags), .drive_state_flags(drive_state_flags),
      .media_req(media_req), .media_go(media_go),
      .lock_disable(lock_disable));
   // Media side finishes each step on the following cycle
   always @(negedge core_clk) begin
      media_done <= media_go;
      track0_found <= t0_ok;
      if (lock_disable) n_unlock++;
      if (media_go) begin
         n_go++;
         if (n_go == 1) first_req = media_req;
         last_req = media_req;
         media_unc <= (n_go == unc_at);
      end else
         media_unc <= 1'b0;
   end
   task automatic chk(input string what, input logic [39:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic go(input logic [7:0] op, input task_file_t tf);
      n_go = 0;
      n_unlock = 0;
      host.issue(tf, op);
   endtask
   // Bounded wait for busy and data request to clear, then settle
   task automatic wait_idle;
      int i;
      for (i = 0; i < 3000 && (drive_state_flags[ST_BSY] !== 1'b0 ||
           drive_state_flags[ST_DRQ] !== 1'b0); i++)
         @(negedge core_clk);
      repeat (2) @(negedge core_clk);
   endtask
   // Two sectors in block mode with retries off
   task automatic t_verify;
      go(8'h41, {8'h02, 8'h34, 8'h12, 8'h56, 8'he7});
      wait_idle;
      chk("steps", 2, n_go);
      chk("start", 28'h7561234, first_req.lba);
      chk("no retry", 1, first_req.no_retry);
      chk("left", 0, tf_rd.count);
      chk("last", 8'h35, tf_rd.sector);
      chk("status", STATUS_IDLE, drive_state_flags);
   endtask
   // Count zero, failure on the third sector across a byte carry
   task automatic t_verify_unc;
      unc_at = 3;
      go(OP_VERIFY, {8'h00, 8'hfe, 8'h00, 8'h00, 8'he0});
      wait_idle;
      unc_at = 0;
      chk("unc steps", 3, n_go);
      chk("unc left", 8'hfe, tf_rd.count);
      chk("unc addr", 16'h0100, {tf_rd.cyl_lo, tf_rd.sector});
      chk("unc flag", 1, error_flags[ERR_UNC]);
      chk("retry on", 0, first_req.no_retry);
   endtask
   task automatic t_recal;
      t0_ok = 1'b0;
      go(8'h1c, tf_wr);
      wait_idle;
      chk("recal", 1, first_req.recal);
      chk("track0", 1, error_flags[ERR_TON]);
      chk("err bit", 1, drive_state_flags[ST_ERR]);
      t0_ok = 1'b1;
      go(8'h10, tf_wr);
      wait_idle;
      chk("recal ok", STATUS_IDLE, drive_state_flags);
   endtask
   // user, master, then master selector with the user password
   task automatic t_unlock;
      int i;
      for (i = 0; i < 3; i++) begin
         go(OP_LOCK_OFF, tf_wr);
         chk("drq", 1, drive_state_flags[ST_DRQ]);
         host.send_sector(i > 0, (i == 1) ? PW_M : PW_U, i);
         wait_idle;
         chk("unlock", i < 2, n_unlock);
         chk("abort", i == 2, error_flags[ERR_ABT]);
      end
   endtask
   task automatic t_erase;
      int i;
      go(OP_ERASE_UNIT, tf_wr);
      wait_idle;
      chk("unarmed", 1, error_flags[ERR_ABT]);
      go(OP_ERASE_PREP, tf_wr);
      wait_idle;
      chk("prep", STATUS_IDLE, drive_state_flags);
      go(OP_ERASE_UNIT, tf_wr);
      host.send_sector(1'b0, PW_M, 0);
      wait_idle;
      chk("bad pw", 1, error_flags[ERR_ABT]);
      chk("bad steps", 0, n_go);
      for (i = 0; i < 2; i++) begin
         lock_enabled = (i == 0);
         go(OP_ERASE_PREP, tf_wr);
         wait_idle;
         go(OP_ERASE_UNIT, tf_wr);
         chk("erase drq", i == 0, drive_state_flags[ST_DRQ]);
         if (i == 0) host.send_sector(1'b0, PW_U, 0);
         wait_idle;
         chk("erase steps", 4, n_go);
         chk("erase first", 0, first_req.lba);
         chk("erase last", native_max, last_req.lba);
         chk("erase kind", 1, last_req.erase);
         if (i == 0) chk("lock off", 1, n_unlock);
         chk("erase done", STATUS_IDLE, drive_state_flags);
      end
   endtask
   task automatic end_of_test;
      if (n_errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(negedge core_clk);
      rst_b = 1'b1;
      chk("reset status", STATUS_IDLE, drive_state_flags);
      chk("reset head", DH_FIXED, tf_rd.dev_head);
      t_verify;
      t_verify_unc;
      t_recal;
      t_unlock;
      t_erase;
      end_of_test;
   end
   // Whole run is a few thousand cycles
   initial begin
      #500000;
      n_errors++;
      end_of_test;
   end
endmodule
bind ata_cmd_exec ata_cmd_checker chk_i (.core_clk(core_clk),
   .rst_b(rst_b), .opcode_entry(opcode_entry), .opcode_wr(opcode_wr),
   .data_wr(data_wr), .lock_enabled(lock_enabled),
   .native_max(native_max), .media_done(media_done),
   .media_unc(media_unc), .track0_found(track0_found),
   .error_flags(error_flags), .drive_state_flags(drive_state_flags),
   .media_req(media_req), .media_go(media_go));
